// ---- design/clock_ratio_divider.sv ----
// Purpose: Power-of-two divider of a source tick, ratio picked by a 3-bit code.
// Assumes: tick_in is a one-cycle qualifier in the sys_clk_in domain.
// Notes: A new code takes effect only at the end of a whole output period.
`timescale 1ns/1ps
module clock_ratio_divider (
  input  wire logic       sys_clk_in,
  input  wire logic       rst_b_in,
  input  wire logic       tick_in,
  input  wire logic [2:0] code_in,
  output logic            tick_out,
  output logic            wrap_out
);
  logic [7:0] count_q;
  logic [3:0] shift_q;
  logic [8:0] span;
  logic [7:0] mask;

  assign span     = 9'h1 << shift_q;
  assign mask     = 8'(span - 9'h1);
  assign wrap_out = tick_in && (count_q == mask);

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      count_q <= 8'h0;
    end else if (wrap_out) begin
      count_q <= 8'h0;
    end else if (tick_in) begin
      count_q <= count_q + 8'h1;
    end
  end

  // Latching the ratio only at a wrap avoids a runt period on the output.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      shift_q <= 4'h0;
    end else if (wrap_out) begin
      shift_q <= osc_ctrl_pkg::div_shift(code_in);
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tick_out <= 1'b0;
    end else begin
      tick_out <= wrap_out;
    end
  end
endmodule

// ---- design/osc_ctrl_params.svh ----
// Purpose: Offsets, field positions, reset values and keys of the oscillator control block.
// Assumes: Byte addresses on a 4-bit Avalon-MM address; each register is one 32-bit word.
// Notes: Definitions only.
`ifndef OSC_CTRL_PARAMS_SVH
`define OSC_CTRL_PARAMS_SVH

// ==========================================================================
// Register offsets
`define OSC_CONTROL_OFS 4'h0
`define FRC_TUNE_OFS    4'h4
`define UNLOCK_KEY_OFS  4'h8

// ==========================================================================
// Field positions
`define PLL_POST_LSB  27
`define RC_DIV_LSB    24
`define SOSC_RDY_BIT  22
`define BUS_RDY_BIT   21
`define BUS_DIV_LSB   19
`define PLL_MULT_LSB  16
`define CUR_OSC_LSB   12
`define NEW_OSC_LSB   8
`define USB_LOCK_BIT  6
`define SYS_LOCK_BIT  5
`define SOSC_EN_BIT   1

// ==========================================================================
// Masks, reset values and unlock keys
`define OSC_WMASK     32'h3f1f_079f
`define BUS_DIV_MASK  32'h0018_0000
`define OSC_RESET     32'h0118_0000
`define TUNE_WMASK    32'h0000_003f
`define TUNE_RESET    32'h0000_0000
`define UNLOCK_KEY1   32'hc0de_0001
`define UNLOCK_KEY2   32'hc0de_0002

`endif

// ---- design/osc_ctrl_pkg.sv ----
// Purpose: Types shared by the oscillator control block.
// Assumes: Constants live in osc_ctrl_params.svh.
// Notes: None.
package osc_ctrl_pkg;

  // ========================================================================
  // Carriers
  typedef struct packed {
    logic [2:0] pll_post_divider;
    logic [1:0] bus_clock_divider;
    logic [2:0] pll_multiplier;
    logic [2:0] new_osc_select;
    logic       secondary_osc_enable;
  } osc_config_type;

  typedef struct packed {
    logic [3:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } avalon_req_type;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } avalon_rsp_type;

  typedef enum logic [1:0] {
    locked_st    = 2'b00,
    key1_seen_st = 2'b01,
    unlocked_st  = 2'b11
  } unlock_state_type;

  // Divider code to power of two: codes 0..6 give 2**code, code 7 gives 256.
  function automatic logic [3:0] div_shift(input logic [2:0] code);
    return (code == 3'h7) ? 4'h8 : {1'b0, code};
  endfunction

endpackage

// ---- design/oscillator_control_divider_regs.sv ----
// Purpose: Oscillator control and RC tuning registers with unlock and clock dividers.
// Assumes: Avalon-MM slave with byte addresses; configuration bits stable from reset.
// Notes: Every access answers after one wait cycle; unmapped reads return zero.
`timescale 1ns/1ps
`include "osc_ctrl_params.svh"
module oscillator_control_divider_regs (
  input  wire logic                        sys_clk_in,
  input  wire logic                        rst_b_in,
  input  wire osc_ctrl_pkg::avalon_req_type avm_req_in,
  output osc_ctrl_pkg::avalon_rsp_type      avm_rsp_out,
  input  wire osc_ctrl_pkg::osc_config_type cfg_in,
  input  wire logic [2:0]                  current_osc_select_in,
  input  wire logic                        sosc_stable_in,
  input  wire logic                        usb_pll_locked_in,
  input  wire logic                        sys_pll_locked_in,
  input  wire logic                        pll_tick_in,
  input  wire logic                        rc_tick_in,
  output osc_ctrl_pkg::osc_config_type      settings_out,
  output logic [2:0]                       rc_clock_divider_out,
  output logic [5:0]                       rc_tune_value_out,
  output logic                             pll_post_tick_out,
  output logic                             rc_div_tick_out,
  output logic                             peripheral_bus_tick_out,
  output logic                             bus_divider_ready_out,
  output logic                             secondary_osc_ready_out
);
  // ========================================================================
  // Bus handshake
  logic                            ack_q;
  logic                            req;
  logic                            take;
  logic [31:0]                     readdata_q;
  logic [31:0]                     byte_mask;
  logic [31:0]                     osc_q;
  logic [31:0]                     tune_q;
  logic [31:0]                     osc_word;
  logic [31:0]                     wr_mask;
  logic                            loaded_q;
  logic                            bus_pending_q;
  logic                            bus_ready;
  logic                            pb_wrap;
  logic                            osc_wr;
  logic                            tune_wr;
  logic                            key_wr;
  logic [2:0]                      s1_q;
  logic [2:0]                      s2_q;
  logic [2:0]                      s3_q;
  logic [2:0]                      stat_q;
  logic                            sosc_ready;
  osc_ctrl_pkg::unlock_state_type  unlock_q;

  assign req  = avm_req_in.read || avm_req_in.write;
  assign take = req && ack_q;
  assign avm_rsp_out.waitrequest = req && !ack_q;
  assign avm_rsp_out.readdata    = readdata_q;

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req && !ack_q;
    end
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      byte_mask[i*8 +: 8] = {8{avm_req_in.byteenable[i]}};
    end
  end

  assign osc_wr  = take && avm_req_in.write && avm_req_in.address == `OSC_CONTROL_OFS;
  assign tune_wr = take && avm_req_in.write && avm_req_in.address == `FRC_TUNE_OFS;
  assign key_wr  = take && avm_req_in.write && avm_req_in.address == `UNLOCK_KEY_OFS
                   && avm_req_in.byteenable == 4'hf;

  // ========================================================================
  // Unlock sequence: key one then key two, in two consecutive key writes
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      unlock_q <= osc_ctrl_pkg::locked_st;
    end else if (key_wr) begin
      if (avm_req_in.writedata == `UNLOCK_KEY1) begin
        unlock_q <= osc_ctrl_pkg::key1_seen_st;
      end else if (unlock_q == osc_ctrl_pkg::key1_seen_st
                   && avm_req_in.writedata == `UNLOCK_KEY2) begin
        unlock_q <= osc_ctrl_pkg::unlocked_st;
      end else begin
        unlock_q <= osc_ctrl_pkg::locked_st;
      end
    end
  end

  // ========================================================================
  // Status synchronisers: a change counts once stages two and three agree
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s1_q   <= 3'h0;
      s2_q   <= 3'h0;
      s3_q   <= 3'h0;
      stat_q <= 3'h0;
    end else begin
      s1_q   <= {sosc_stable_in, usb_pll_locked_in, sys_pll_locked_in};
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      stat_q <= (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & stat_q);
    end
  end

  // A disabled oscillator is never reported ready, even while its pin still toggles.
  assign sosc_ready = stat_q[2] && osc_q[`SOSC_EN_BIT];

  // ========================================================================
  // Control register
  assign bus_ready = !bus_pending_q;
  // The bus divider field is frozen while a ratio change is in flight.
  assign wr_mask = byte_mask & `OSC_WMASK & ~(bus_ready ? 32'h0 : `BUS_DIV_MASK);

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      loaded_q <= 1'b0;
    end else begin
      loaded_q <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      osc_q <= `OSC_RESET;
    end else if (!loaded_q) begin
      osc_q[`PLL_POST_LSB +: 3] <= cfg_in.pll_post_divider;
      osc_q[`BUS_DIV_LSB +: 2]  <= cfg_in.bus_clock_divider;
      osc_q[`PLL_MULT_LSB +: 3] <= cfg_in.pll_multiplier;
      osc_q[`NEW_OSC_LSB +: 3]  <= cfg_in.new_osc_select;
      osc_q[`SOSC_EN_BIT]       <= cfg_in.secondary_osc_enable;
    end else if (osc_wr && unlock_q == osc_ctrl_pkg::unlocked_st) begin
      osc_q <= (osc_q & ~wr_mask) | (avm_req_in.writedata & wr_mask);
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tune_q <= `TUNE_RESET;
    end else if (tune_wr && unlock_q == osc_ctrl_pkg::unlocked_st) begin
      tune_q <= (tune_q & ~(byte_mask & `TUNE_WMASK))
                | (avm_req_in.writedata & byte_mask & `TUNE_WMASK);
    end
  end

  // A set in the wrap cycle wins, so the new ratio is caught at the following wrap.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      bus_pending_q <= 1'b0;
    end else if (osc_wr && unlock_q == osc_ctrl_pkg::unlocked_st && bus_ready
                 && |((osc_q ^ avm_req_in.writedata) & byte_mask & `BUS_DIV_MASK)) begin
      bus_pending_q <= 1'b1;
    end else if (pb_wrap) begin
      bus_pending_q <= 1'b0;
    end
  end

  // ========================================================================
  // Read path; current oscillator and lock bits come only from hardware.
  always_comb begin
    osc_word = osc_q & `OSC_WMASK;
    osc_word[`SOSC_RDY_BIT] = sosc_ready;
    osc_word[`BUS_RDY_BIT] = bus_ready;
    osc_word[`CUR_OSC_LSB +: 3] = current_osc_select_in;
    osc_word[`USB_LOCK_BIT] = stat_q[1];
    osc_word[`SYS_LOCK_BIT] = stat_q[0];
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      readdata_q <= 32'h0;
    end else if (avm_req_in.read && !ack_q) begin
      case (avm_req_in.address)
        `OSC_CONTROL_OFS: readdata_q <= osc_word;
        `FRC_TUNE_OFS:    readdata_q <= tune_q & `TUNE_WMASK;
        `UNLOCK_KEY_OFS:  readdata_q <= {30'h0, unlock_q};
        default:          readdata_q <= 32'h0;
      endcase
    end
  end

  // ========================================================================
  // Dividers
  clock_ratio_divider pll_post_div (
    .sys_clk_in (sys_clk_in),
    .rst_b_in   (rst_b_in),
    .tick_in    (pll_tick_in),
    .code_in    (osc_q[`PLL_POST_LSB +: 3]),
    .tick_out   (pll_post_tick_out),
    .wrap_out   ()
  );

  clock_ratio_divider rc_div (
    .sys_clk_in (sys_clk_in),
    .rst_b_in   (rst_b_in),
    .tick_in    (rc_tick_in),
    .code_in    (osc_q[`RC_DIV_LSB +: 3]),
    .tick_out   (rc_div_tick_out),
    .wrap_out   ()
  );

  // Bus codes 0..3 map onto divide by 1, 2, 4 and 8.
  clock_ratio_divider pb_div (
    .sys_clk_in (sys_clk_in),
    .rst_b_in   (rst_b_in),
    .tick_in    (1'b1),
    .code_in    ({1'b0, osc_q[`BUS_DIV_LSB +: 2]}),
    .tick_out   (peripheral_bus_tick_out),
    .wrap_out   (pb_wrap)
  );

  assign settings_out.pll_post_divider     = osc_q[`PLL_POST_LSB +: 3];
  assign settings_out.bus_clock_divider    = osc_q[`BUS_DIV_LSB +: 2];
  assign settings_out.pll_multiplier       = osc_q[`PLL_MULT_LSB +: 3];
  assign settings_out.new_osc_select       = osc_q[`NEW_OSC_LSB +: 3];
  assign settings_out.secondary_osc_enable = osc_q[`SOSC_EN_BIT];
  assign rc_clock_divider_out              = osc_q[`RC_DIV_LSB +: 3];
  assign rc_tune_value_out                 = tune_q[5:0];
  assign bus_divider_ready_out             = bus_ready;
  assign secondary_osc_ready_out           = sosc_ready;

  // ========================================================================
  // Checks
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);

  sequence key1_s;
    key_wr && avm_req_in.writedata == `UNLOCK_KEY1;
  endsequence
  sequence key2_s;
    key_wr && avm_req_in.writedata == `UNLOCK_KEY2;
  endsequence

  reserved_bits_zero_a: assert property (
    osc_word[31:30] == 2'h0 && !osc_word[23])
    else $error("reserved control bits not zero");
  locked_write_blocked_a: assert property (
    osc_wr && unlock_q != osc_ctrl_pkg::unlocked_st |=> $stable(osc_q))
    else $error("control register changed while locked");
  unlock_sequence_a: assert property (
    key1_s ##[2:3] key2_s |=> unlock_q == osc_ctrl_pkg::unlocked_st)
    else $error("unlock sequence did not unlock");
  bus_div_frozen_a: assert property (
    !bus_ready && loaded_q |=> $stable(osc_q[`BUS_DIV_LSB +: 2]))
    else $error("bus divider changed while not ready");
  bus_ready_return_a: assert property (
    $fell(bus_ready) |-> ##[1:9] bus_ready)
    else $error("bus divider ready did not return");
  pb_div8_period_a: assert property (
    peripheral_bus_tick_out && bus_ready && osc_q[`BUS_DIV_LSB +: 2] == 2'h3
    && $stable(osc_q[`BUS_DIV_LSB +: 2])
    |=> !peripheral_bus_tick_out [*7] ##1 peripheral_bus_tick_out)
    else $error("peripheral tick period not eight");
  sosc_ready_gate_a: assert property (
    sosc_ready |-> osc_q[`SOSC_EN_BIT] && (s3_q[2] || $past(s3_q[2])))
    else $error("secondary ready without stable oscillator");
  rc_div_reset_a: assert property (
    !loaded_q |-> osc_q[`RC_DIV_LSB +: 3] == 3'h1)
    else $error("rc divider reset code wrong");
  cfg_load_a: assert property (
    rst_b_in && !loaded_q |=> osc_q[`PLL_POST_LSB +: 3] == $past(cfg_in.pll_post_divider)
    && osc_q[`BUS_DIV_LSB +: 2] == $past(cfg_in.bus_clock_divider))
    else $error("configuration fields not loaded");
endmodule

// ---- testbench/tb.sv ----
// Purpose: Self-checking bench for the oscillator control and RC tuning registers.
// Assumes: Bus tasks wait for waitrequest low; divider tick inputs held high every cycle.
// Notes: Expected values are built from field positions, never from design outputs.
`timescale 1ns/1ps
`include "osc_ctrl_params.svh"
module tb;
  // ==========================================================================
  // Signals and design instance
  logic                         sys_clk_in;
  logic                         rst_b_in;
  osc_ctrl_pkg::avalon_req_type req;
  osc_ctrl_pkg::avalon_rsp_type rsp;
  osc_ctrl_pkg::osc_config_type cfg;
  osc_ctrl_pkg::osc_config_type settings;
  logic                         sosc_stable;
  logic [2:0]                   rc_div;
  logic [5:0]                   tune;
  logic                         pll_tk;
  logic                         rc_tk;
  logic                         bus_tk;
  logic                         bus_rdy;
  logic                         sosc_rdy;
  logic [31:0]                  exp_osc;
  logic [31:0]                  d;
  logic                         sosc_exp;
  int                           num_errors;
  int                           n_checks;
  int                           p;

  oscillator_control_divider_regs oscillator_control_divider_regs_inst (
    .sys_clk_in              (sys_clk_in),
    .rst_b_in                (rst_b_in),
    .avm_req_in              (req),
    .avm_rsp_out             (rsp),
    .cfg_in                  (cfg),
    .current_osc_select_in   (3'h5),
    .sosc_stable_in          (sosc_stable),
    .usb_pll_locked_in       (1'b1),
    .sys_pll_locked_in       (1'b0),
    .pll_tick_in             (1'b1),
    .rc_tick_in              (1'b1),
    .settings_out            (settings),
    .rc_clock_divider_out    (rc_div),
    .rc_tune_value_out       (tune),
    .pll_post_tick_out       (pll_tk),
    .rc_div_tick_out         (rc_tk),
    .peripheral_bus_tick_out (bus_tk),
    .bus_divider_ready_out   (bus_rdy),
    .secondary_osc_ready_out (sosc_rdy)
  );

  always #2 sys_clk_in = ~sys_clk_in;

  // ==========================================================================
  // Checking and bus tasks
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, e, g);
    end
  endtask

  // Called just after a rising edge; returns one edge after the request is released.
  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] wd,
                      output logic [31:0] rdv);
    int i;
    req.address    <= a;
    req.write      <= w;
    req.read       <= !w;
    req.writedata  <= wd;
    req.byteenable <= 4'hf;
    rdv = 32'h0;
    // The request stands until the rising edge at which waitrequest is seen low.
    for (i = 0; i < 20; i++) begin
      @(posedge sys_clk_in);
      if (rsp.waitrequest === 1'b0) break;
    end
    if (i == 20) begin
      num_errors++;
      results();
    end
    rdv = rsp.readdata;
    req.read  <= 1'b0;
    req.write <= 1'b0;
    @(posedge sys_clk_in);
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] wd);
    logic [31:0] x;
    xfer(1'b1, a, wd, x);
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] x);
    xfer(1'b0, a, 32'h0, x);
  endtask

  function automatic logic tk(input int sel);
    return (sel == 0) ? pll_tk : (sel == 1) ? rc_tk : bus_tk;
  endfunction

  // Cycles between two ticks; the first period after a code change is discarded.
  task automatic period(input int sel, output int n);
    int i;
    i = 0;
    do begin
      @(negedge sys_clk_in);
      i++;
    end while (!tk(sel) && i < 600);
    n = 0;
    do begin
      @(negedge sys_clk_in);
      n++;
    end while (!tk(sel) && n < 600);
    if (n >= 600) begin
      num_errors++;
      results();
    end
    @(posedge sys_clk_in);
  endtask

  function automatic logic [31:0] osc_read();
    return exp_osc | (32'(sosc_exp) << 22) | (32'h1 << 21) | (32'h5 << 12) | (32'h1 << 6);
  endfunction

  // ==========================================================================
  // Test sequence
  initial begin
    sys_clk_in  = 1'b0;
    rst_b_in    = 1'b0;
    req         = '0;
    sosc_stable = 1'b0;
    sosc_exp    = 1'b0;
    num_errors  = 0;
    n_checks    = 0;
    cfg         = '{3'h2, 2'h3, 3'h4, 3'h6, 1'b0};
    repeat (2) @(posedge sys_clk_in);
    rst_b_in <= 1'b1;
    // The lock status inputs need a few cycles to pass their synchronisers.
    repeat (6) @(posedge sys_clk_in);
    exp_osc = (32'h2 << 27) | (32'h1 << 24) | (32'h3 << 19) | (32'h4 << 16) | (32'h6 << 8);
    rd(`OSC_CONTROL_OFS, d);
    chk("osc after reset", osc_read(), d);
    rd(`FRC_TUNE_OFS, d);
    chk("tune after reset", 32'h0, d);
    $display("test reset done");
    wr(`OSC_CONTROL_OFS, 32'hffff_ffff);
    wr(`FRC_TUNE_OFS, 32'hffff_ffff);
    rd(`OSC_CONTROL_OFS, d);
    chk("osc locked", osc_read(), d);
    rd(`FRC_TUNE_OFS, d);
    chk("tune locked", 32'h0, d);
    wr(`UNLOCK_KEY_OFS, `UNLOCK_KEY1);
    wr(`UNLOCK_KEY_OFS, `UNLOCK_KEY2);
    rd(`UNLOCK_KEY_OFS, d);
    chk("unlock state", 32'h3, d);
    wr(`OSC_CONTROL_OFS, 32'hffff_ffff);
    exp_osc = `OSC_WMASK;
    rd(`OSC_CONTROL_OFS, d);
    chk("osc all ones", osc_read(), d);
    wr(`FRC_TUNE_OFS, 32'hffff_ffff);
    rd(`FRC_TUNE_OFS, d);
    chk("tune all ones", 32'h3f, d);
    chk("tune port", 32'h3f, 32'(tune));
    $display("test unlock done");
    for (int c = 0; c < 8; c++) begin
      exp_osc = (exp_osc & ~32'h3f00_0000) | (32'(c) << 27) | (32'(c) << 24);
      wr(`OSC_CONTROL_OFS, exp_osc);
      period(0, p);
      period(0, p);
      chk("pll period", (c == 7) ? 32'd256 : 32'd1 << c, 32'(p));
      period(1, p);
      period(1, p);
      chk("rc period", (c == 7) ? 32'd256 : 32'd1 << c, 32'(p));
    end
    chk("rc divider port", 32'h7, 32'(rc_div));
    $display("test dividers done");
    period(2, p);
    chk("bus period default", 32'd8, 32'(p));
    for (int c = 0; c < 4; c++) begin
      exp_osc = (exp_osc & ~`BUS_DIV_MASK) | (32'(c) << 19);
      wr(`OSC_CONTROL_OFS, exp_osc);
      if (c == 0) begin
        wr(`OSC_CONTROL_OFS, exp_osc | `BUS_DIV_MASK);
        chk("bus ready low", 32'h0, 32'(bus_rdy));
      end
      for (int i = 0; i < 20; i++) begin
        rd(`OSC_CONTROL_OFS, d);
        if (d[21] === 1'b1) break;
      end
      chk("osc bus code", osc_read(), d);
      chk("bus code port", 32'(c), 32'(settings.bus_clock_divider));
      period(2, p);
      period(2, p);
      chk("bus period", 32'd1 << c, 32'(p));
    end
    $display("test bus divider done");
    sosc_stable <= 1'b1;
    sosc_exp = 1'b1;
    repeat (8) @(posedge sys_clk_in);
    rd(`OSC_CONTROL_OFS, d);
    chk("sosc ready set", osc_read(), d);
    chk("sosc ready port", 32'h1, 32'(sosc_rdy));
    sosc_stable <= 1'b0;
    sosc_exp = 1'b0;
    repeat (8) @(posedge sys_clk_in);
    rd(`OSC_CONTROL_OFS, d);
    chk("sosc ready clear", osc_read(), d);
    $display("test secondary ready done");
    wr(`UNLOCK_KEY_OFS, 32'h0);
    rd(`UNLOCK_KEY_OFS, d);
    chk("relocked state", 32'h0, d);
    wr(`FRC_TUNE_OFS, 32'h0);
    rd(`FRC_TUNE_OFS, d);
    chk("tune relocked", 32'h3f, d);
    rd(4'hc, d);
    chk("unmapped read", 32'h0, d);
    $display("test relock done");
    results();
  end
endmodule
